// File: dual_uart_host_bus_and_pins_test.sv
`timescale 1ns/10ps
module dual_uart_host_bus_and_pins_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, txa, txb;
  logic [1:0]  bresp, rresp;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, s;
  logic [7:0]  gpo, gpo_oe, v, iv;
  int          failures, samples_checked, n;
  duart_bus_if bus ();
  duart_dev #(.BAUD_DIV(2)) u_duart_dev (.aclk, .aresetn, .bus,
    .serial_in_chan_a(txb), .serial_in_chan_b(txa),
    .serial_out_chan_a(txa), .serial_out_chan_b(txb),
    .general_outputs(gpo), .general_outputs_oe(gpo_oe));
  duart_host u_duart_host (.aclk, .aresetn, .bus, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  duart_checker u_duart_checker (.aclk, .aresetn,
    .chip_select_low(bus.chip_select_low),
    .read_write_select(bus.read_write_select),
    .irq_ack_low(bus.irq_ack_low), .dev_data_oe(bus.dev_data_oe),
    .transfer_ack_low(bus.transfer_ack_low),
    .irq_request_low(bus.irq_request_low));
  task automatic final_report();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic check(input string t, input logic [31:0] a, e);
    samples_checked++;
    if (a !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", t, e, a);
    end
  endtask : check
  task automatic tmo();
    failures += (n >= 300);
    if (n >= 300) final_report();
  endtask : tmo
  function automatic logic [1:0] resp(input logic [3:0] a, ok);
    return (a == ok) ? duart_pkg::RESP_OKAY : duart_pkg::RESP_SLV;
  endfunction : resp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 300);
    bready <= 1'b0;
    check("bresp", bresp, resp(a, duart_pkg::AXI_CMD));
    tmo();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 300);
    rready <= 1'b0;
    s = rdata;
    check("rresp", rresp, resp(a, duart_pkg::AXI_STATUS));
    tmo();
  endtask : rd
  task automatic cmd(input logic [1:0] op, input logic [3:0] r,
                     input logic [7:0] d);
    int k;
    wr(duart_pkg::AXI_CMD, {18'h0, op, r, d});
    k = 0;
    // poll status until the bus cycle is over: busy low, done high
    do
    begin
      rd(duart_pkg::AXI_STATUS);
      k++;
    end while (s[9:8] !== 2'h2 && k < 300);
    n = k;
    tmo();
  endtask : cmd
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, s} = '0;
    wstrb = 4'hF;
    n = $urandom(5);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check("tx", {txa, txb}, 3);
    check("gpo", {gpo_oe, gpo}, 16'hFFFF);
    cmd(1, duart_pkg::SEL_IVR, 0);
    check("ivr", s[7:0], duart_pkg::IVR_RESET);
    cmd(1, duart_pkg::SEL_IRQ, 0);
    check("isr", s[7:0], duart_pkg::REG8_RESET);
    repeat (4)
    begin
      iv = 8'($urandom);
      cmd(0, duart_pkg::SEL_IVR, iv);
      cmd(1, duart_pkg::SEL_IVR, 0);
      check("ivr", s[7:0], iv);
      cmd(0, duart_pkg::SEL_OP_SET, iv);
      check("gpo", gpo, 8'(~iv));
      cmd(0, duart_pkg::SEL_OP_CLR, iv);
    end
    wr(4'h8, 0);
    rd(4'h8);
    check("rdata", s, 0);
    cmd(0, duart_pkg::SEL_CTRL_A, 1);
    cmd(0, duart_pkg::SEL_CTRL_B, 2);
    cmd(0, duart_pkg::SEL_IRQ, 2);
    check("irq", bus.irq_request_low, 1);
    v = 8'($urandom);
    wr(duart_pkg::AXI_CMD, {20'h0, duart_pkg::SEL_DATA_B, v});
    for (n = 0; n < 300 && txb; n++) @(posedge aclk);
    tmo();
    for (int i = 0; i < 8; i++)
    begin
      repeat (i == 0 ? 48 : 32) @(posedge aclk);
      check("txb", txb, v[i]);
    end
    repeat (64) @(posedge aclk);
    check("txa", txa, 1);
    check("irq", bus.irq_request_low, 0);
    cmd(0, duart_pkg::SEL_OUTPUT_PORT_CONFIG_REG, 8'h14);
    check("rxrdy", {gpo_oe[4], gpo[4]}, 2);
    check("ctout", gpo_oe[3], 0);
    cmd(2, 0, 0);
    check("vector", s[7:0], iv);
    cmd(1, duart_pkg::SEL_DATA_A, 0);
    check("rxa", s[7:0], v);
    check("rxrdy", gpo_oe[4], 0);
    cmd(2, 0, 0);
    check("nack", s[10], 1);
    final_report();
  end
endmodule : dual_uart_host_bus_and_pins_test

// File: duart_bus_if.sv
`timescale 1ns/10ps
interface duart_bus_if;
  logic       chip_select_low;
  logic       read_write_select;
  logic [3:0] register_select_lines;
  logic       irq_ack_low;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic       ack_out;
  logic       ack_oe;
  logic       irq_oe;
  logic [7:0] host_data_bus;
  logic       transfer_ack_low;
  logic       irq_request_low;

  // wire levels; undriven lines pull high
  assign host_data_bus    = dev_data_oe ? dev_data_out :
                            (host_data_oe ? host_data_out : 8'hFF);
  assign transfer_ack_low = ack_oe ? ack_out : 1'b1;
  assign irq_request_low  = irq_oe ? 1'b0 : 1'b1;

  modport dev (
    input  chip_select_low, read_write_select, register_select_lines,
    input  irq_ack_low, host_data_bus,
    output dev_data_out, dev_data_oe, ack_out, ack_oe, irq_oe
  );
  modport host (
    output chip_select_low, read_write_select, register_select_lines,
    output irq_ack_low, host_data_out, host_data_oe,
    input  host_data_bus, transfer_ack_low, irq_request_low
  );
endinterface : duart_bus_if

// File: duart_checker.sv
`timescale 1ns/10ps
module duart_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_select_low,
  input wire logic read_write_select,
  input wire logic irq_ack_low,
  input wire logic dev_data_oe,
  input wire logic transfer_ack_low,
  input wire logic irq_request_low
);
  wire cs = !chip_select_low;
  wire ak = !transfer_ack_low;
  wire ia = !irq_ack_low;
  wire rw = read_write_select;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bus_float_a: assert property (
    !cs && !ia && !$past(cs) && !$past(ia) |-> !dev_data_oe)
    else $error("bus driven");
  ack_answer_a: assert property (
    $rose(cs) |=> ak) else $error("no ack");
  ack_release_a: assert property (
    $fell(cs) && !ia |=> !ak) else $error("ack stuck");
  read_data_a: assert property (
    cs && rw && ak |-> dev_data_oe) else $error("no read data");
  write_float_a: assert property (
    cs && !rw |-> !dev_data_oe) else $error("write clash");
  host_hold_a: assert property (
    cs && !ak |=> cs && $stable(rw)) else $error("host let go");
  vector_out_a: assert property (
    !cs && ia && ak |-> dev_data_oe) else $error("no vector");
  iack_quiet_a: assert property (
    !cs && ia && irq_request_low ##1 irq_request_low |-> !ak)
    else $error("stray ack");
  cover property (cs && rw && ak);
  cover property (cs && !rw && ak);
  cover property (ia && ak);
endmodule : duart_checker

// File: duart_dev.sv
`timescale 1ns/10ps
module duart_dev #(
  parameter int unsigned BAUD_DIV = duart_pkg::BAUD_DIV16
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  duart_bus_if.dev        bus,
  input  wire logic       serial_in_chan_a,
  input  wire logic       serial_in_chan_b,
  output logic            serial_out_chan_a,
  output logic            serial_out_chan_b,
  output logic [7:0]      general_outputs,
  output logic [7:0]      general_outputs_oe
);
  logic [15:0] div_reg;
  logic        tick16_reg;
  logic        clk16_reg;
  logic        acked_reg;
  logic [7:0]  ctrl_reg [2];
  logic [7:0]  imr_reg;
  logic [7:0]  ivr_reg;
  logic [7:0]  opr_reg;
  logic [7:0]  output_port_config_reg_reg;
  logic [15:0] ct_preload_reg;
  logic [15:0] ct_count_reg;
  logic        ct_run_reg;
  logic        ct_out_reg;
  logic        ct_flag_reg;
  logic [7:0]  interrupt_status_reg;
  logic [7:0]  rd_data;
  logic [7:0]  wd;
  logic [3:0]  sel;
  logic        pending;
  logic        cs_start;
  logic        iack_start;
  logic        wr;
  logic        rd;
  logic [1:0]  ser_in;
  logic [1:0]  ser_out;
  logic [1:0]  tx_ready;
  logic [1:0]  tx_done;
  logic [1:0]  rx_ready;
  logic [1:0]  rx_ovr;
  logic [1:0]  tx_clk1x;
  logic [1:0]  rx_clk1x;
  logic [7:0]  rx_data [2];
  logic [7:0]  gp_next;
  logic [7:0]  gp_oe_next;

  assign sel = bus.register_select_lines;
  assign wd  = bus.host_data_bus;
  assign pending = |(interrupt_status_reg & imr_reg);
  assign cs_start = !bus.chip_select_low && !acked_reg;
  assign iack_start = bus.chip_select_low && !bus.irq_ack_low &&
                      pending && !acked_reg;
  assign wr = cs_start && !bus.read_write_select;
  assign rd = cs_start && bus.read_write_select;
  assign ser_in = {serial_in_chan_b, serial_in_chan_a};
  assign serial_out_chan_a = ser_out[0];
  assign serial_out_chan_b = ser_out[1];

  // 16x baud tick and 16x clock square wave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg    <= 16'h0000;
      tick16_reg <= 1'b0;
      clk16_reg  <= 1'b0;
    end
    else
    begin
      tick16_reg <= div_reg == 16'h0000;
      clk16_reg  <= div_reg < 16'(BAUD_DIV / 2);
      div_reg    <= (div_reg == 16'(BAUD_DIV - 1)) ? 16'h0000 :
                    div_reg + 16'h0001;
    end
  end

  // one serial channel per index
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [3:0] ctl_sel;
      logic [3:0] dat_sel;
      assign ctl_sel = ch ? duart_pkg::SEL_CTRL_B : duart_pkg::SEL_CTRL_A;
      assign dat_sel = ch ? duart_pkg::SEL_DATA_B : duart_pkg::SEL_DATA_A;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          ctrl_reg[ch] <= duart_pkg::REG8_RESET;
        else if (wr && sel == ctl_sel)
          ctrl_reg[ch] <= wd & 8'h1F;
      end

      duart_serial u_serial (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick16     (tick16_reg),
        .rx_en      (ctrl_reg[ch][duart_pkg::CTL_RX_EN]),
        .tx_en      (ctrl_reg[ch][duart_pkg::CTL_TX_EN]),
        .loop_en    (ctrl_reg[ch][duart_pkg::CTL_LOOP]),
        .tx_load    (wr && sel == dat_sel &&
                     ctrl_reg[ch][duart_pkg::CTL_TX_EN]),
        .tx_data    (wd),
        .rx_pop     (rd && sel == dat_sel),
        .ovr_clear  (wr && sel == ctl_sel &&
                     wd[duart_pkg::CTL_OVR_CLR]),
        .serial_in  (ser_in[ch]),
        .serial_out (ser_out[ch]),
        .tx_ready   (tx_ready[ch]),
        .tx_done    (tx_done[ch]),
        .rx_ready   (rx_ready[ch]),
        .rx_overrun (rx_ovr[ch]),
        .rx_data    (rx_data[ch]),
        .tx_clk1x   (tx_clk1x[ch]),
        .rx_clk1x   (rx_clk1x[ch])
      );
    end
  endgenerate

  // interrupt status from live conditions
  always_comb
  begin
    interrupt_status_reg = 8'h00;
    interrupt_status_reg[duart_pkg::ISR_TX_A] = tx_ready[0] &&
                               ctrl_reg[0][duart_pkg::CTL_TX_EN];
    interrupt_status_reg[duart_pkg::ISR_RX_A] = rx_ready[0];
    interrupt_status_reg[duart_pkg::ISR_CT]   = ct_flag_reg;
    interrupt_status_reg[duart_pkg::ISR_TX_B] = tx_ready[1] &&
                               ctrl_reg[1][duart_pkg::CTL_TX_EN];
    interrupt_status_reg[duart_pkg::ISR_RX_B] = rx_ready[1];
  end

  // read data selection
  always_comb
  begin
    if (sel == duart_pkg::SEL_CTRL_A)
      rd_data = {3'h0, rx_ovr[0], 1'b0, tx_ready[0], 1'b0, rx_ready[0]};
    else if (sel == duart_pkg::SEL_CTRL_B)
      rd_data = {3'h0, rx_ovr[1], 1'b0, tx_ready[1], 1'b0, rx_ready[1]};
    else if (sel == duart_pkg::SEL_DATA_A)
      rd_data = rx_data[0];
    else if (sel == duart_pkg::SEL_DATA_B)
      rd_data = rx_data[1];
    else if (sel == duart_pkg::SEL_CT_HI)
      rd_data = ct_count_reg[15:8];
    else if (sel == duart_pkg::SEL_CT_LO)
      rd_data = ct_count_reg[7:0];
    else if (sel == duart_pkg::SEL_IRQ)
      rd_data = interrupt_status_reg;
    else if (sel == duart_pkg::SEL_IVR)
      rd_data = ivr_reg;
    else if (sel == duart_pkg::SEL_OUTPUT_PORT_CONFIG_REG)
      rd_data = output_port_config_reg_reg;
    else
      rd_data = 8'h00;
  end

  // bus cycle: acknowledge once, hold until select and iack release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acked_reg        <= 1'b0;
      bus.ack_out      <= 1'b1;
      bus.ack_oe       <= 1'b0;
      bus.dev_data_oe  <= 1'b0;
      bus.dev_data_out <= 8'h00;
    end
    else if (cs_start || iack_start)
    begin
      acked_reg        <= 1'b1;
      bus.ack_out      <= 1'b0;
      bus.ack_oe       <= 1'b1;
      bus.dev_data_oe  <= rd || iack_start;
      bus.dev_data_out <= iack_start ? ivr_reg : rd_data;
    end
    else if (bus.chip_select_low && bus.irq_ack_low)
    begin
      acked_reg       <= 1'b0;
      bus.ack_out     <= 1'b1;
      bus.ack_oe      <= 1'b0;
      bus.dev_data_oe <= 1'b0;
    end
  end

  // interrupt request, open drain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus.irq_oe <= 1'b0;
    else
      bus.irq_oe <= pending;
  end

  // mask, vector and output configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      imr_reg  <= duart_pkg::REG8_RESET;
      output_port_config_reg_reg <= duart_pkg::REG8_RESET;
      ivr_reg  <= duart_pkg::IVR_RESET;
    end
    else if (wr)
    begin
      if (sel == duart_pkg::SEL_IRQ)
        imr_reg <= wd;
      else if (sel == duart_pkg::SEL_OUTPUT_PORT_CONFIG_REG)
        output_port_config_reg_reg <= wd;
      else if (sel == duart_pkg::SEL_IVR)
        ivr_reg <= wd;
    end
  end

  // output port bits; transmit-done auto clears request-to-send
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      opr_reg <= duart_pkg::REG8_RESET;
    else if (wr && sel == duart_pkg::SEL_OP_SET)
      opr_reg <= opr_reg | wd;
    else if (wr && sel == duart_pkg::SEL_OP_CLR)
      opr_reg <= opr_reg & ~wd;
    else
      opr_reg <= opr_reg & ~{6'h00,
                 tx_done[1] && ctrl_reg[1][duart_pkg::CTL_RTS_TX],
                 tx_done[0] && ctrl_reg[0][duart_pkg::CTL_RTS_TX]};
  end

  // counter/timer: reload at zero, toggle output, flag event
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ct_preload_reg <= duart_pkg::CT_RESET;
      ct_count_reg   <= duart_pkg::CT_RESET;
      ct_run_reg     <= 1'b0;
      ct_out_reg     <= 1'b1;
      ct_flag_reg    <= 1'b0;
    end
    else
    begin
      if (wr && sel == duart_pkg::SEL_CT_HI)
        ct_preload_reg[15:8] <= wd;
      if (wr && sel == duart_pkg::SEL_CT_LO)
        ct_preload_reg[7:0] <= wd;
      if (wr && sel == duart_pkg::SEL_CT_CTRL)
      begin
        ct_run_reg   <= wd[0];
        ct_count_reg <= ct_preload_reg;
      end
      else if (ct_run_reg)
      begin
        if (ct_count_reg == 16'h0000)
        begin
          ct_count_reg <= ct_preload_reg;
          ct_out_reg   <= ~ct_out_reg;
        end
        else
          ct_count_reg <= ct_count_reg - 16'h0001;
      end
      ct_flag_reg <= (ct_run_reg && ct_count_reg == 16'h0000) ||
                     (ct_flag_reg && !(wr && sel == duart_pkg::SEL_CT_CTRL));
    end
  end

  // output pin functions; pins default to the complement of the port bits
  always_comb
  begin
    gp_next    = ~opr_reg;
    gp_oe_next = 8'hFF;
    gp_next[0] = ~opr_reg[0] | (rx_ready[0] &&
                 ctrl_reg[0][duart_pkg::CTL_RTS_RX]);
    gp_next[1] = ~opr_reg[1] | (rx_ready[1] &&
                 ctrl_reg[1][duart_pkg::CTL_RTS_RX]);
    case (output_port_config_reg_reg[1:0])
      2'h1: gp_next[2] = clk16_reg;
      2'h2: gp_next[2] = tx_clk1x[0];
      2'h3: gp_next[2] = rx_clk1x[0];
      default: gp_next[2] = ~opr_reg[2];
    endcase
    case (output_port_config_reg_reg[3:2])
      2'h1:
      begin
        gp_next[3]    = 1'b0;
        gp_oe_next[3] = ~ct_out_reg;
      end
      2'h2: gp_next[3] = tx_clk1x[1];
      2'h3: gp_next[3] = rx_clk1x[1];
      default: gp_next[3] = ~opr_reg[3];
    endcase
    if (output_port_config_reg_reg[4])
    begin
      gp_next[4]    = 1'b0;
      gp_oe_next[4] = rx_ready[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      general_outputs    <= 8'hFF;
      general_outputs_oe <= 8'hFF;
    end
    else
    begin
      general_outputs    <= gp_next;
      general_outputs_oe <= gp_oe_next;
    end
  end
endmodule : duart_dev

// File: duart_host.sv
`timescale 1ns/10ps
module duart_host #(
  parameter int unsigned TIMEOUT = duart_pkg::ACK_TIMEOUT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  duart_bus_if.host        bus,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  typedef enum logic [1:0] {H_IDLE, H_ACCESS, H_RELEASE} duart_hst_t;
  duart_hst_t  state_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [3:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [7:0]  cap_reg;
  logic        done_reg;
  logic        noresp_reg;
  logic [7:0]  to_cnt_reg;
  logic        wr_fire;
  logic        go;

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
  assign go = wr_fire && awaddr_reg == duart_pkg::AXI_CMD &&
              state_reg == H_IDLE;

  // AXI write channels, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      bvalid <= 1'b0;
      bresp <= duart_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= wstrb[1:0] == 2'h3 ? wdata : 32'h00000000;
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= awaddr_reg == duart_pkg::AXI_CMD ?
                 duart_pkg::RESP_OKAY : duart_pkg::RESP_SLV;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= duart_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      if (araddr == duart_pkg::AXI_STATUS)
      begin
        rdata <= {20'h00000, !bus.irq_request_low, noresp_reg, done_reg,
                  state_reg != H_IDLE, cap_reg};
        rresp <= duart_pkg::RESP_OKAY;
      end
      else
      begin
        rdata <= 32'h00000000;
        rresp <= duart_pkg::RESP_SLV;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // parallel bus cycle: hold select until acknowledge or timeout, then release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= H_IDLE;
      bus.chip_select_low <= 1'b1;
      bus.read_write_select <= 1'b1;
      bus.register_select_lines <= 4'h0;
      bus.irq_ack_low <= 1'b1;
      bus.host_data_out <= 8'h00;
      bus.host_data_oe <= 1'b0;
      cap_reg <= 8'h00;
      done_reg <= 1'b0;
      noresp_reg <= 1'b0;
      to_cnt_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        H_IDLE:
          if (go)
          begin
            state_reg <= H_ACCESS;
            done_reg <= 1'b0;
            noresp_reg <= 1'b0;
            to_cnt_reg <= 8'h00;
            bus.register_select_lines <= wdata_reg[11:8];
            bus.host_data_out <= wdata_reg[7:0];
            if (wdata_reg[duart_pkg::CMD_IACK])
              bus.irq_ack_low <= 1'b0;
            else
            begin
              bus.chip_select_low <= 1'b0;
              bus.read_write_select <=
                wdata_reg[duart_pkg::CMD_READ];
              bus.host_data_oe <= !wdata_reg[duart_pkg::CMD_READ];
            end
          end
        H_ACCESS:
          if (!bus.transfer_ack_low ||
              to_cnt_reg == 8'(TIMEOUT - 1))
          begin
            state_reg <= H_RELEASE;
            cap_reg <= bus.host_data_bus;
            noresp_reg <= bus.transfer_ack_low;
            bus.chip_select_low <= 1'b1;
            bus.irq_ack_low <= 1'b1;
            bus.host_data_oe <= 1'b0;
          end
          else
            to_cnt_reg <= to_cnt_reg + 8'h01;
        default:
          if (bus.transfer_ack_low)
          begin
            state_reg <= H_IDLE;
            done_reg <= 1'b1;
          end
      endcase
    end
  end
endmodule : duart_host

// File: duart_pkg.sv
package duart_pkg;
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned BAUD_RATE   = 9600;
  localparam int unsigned BAUD_DIV16  = CLK_HZ / (BAUD_RATE * 16);
  localparam int unsigned ACK_TIMEOUT = 64;
  // register select codes
  localparam logic [3:0] SEL_CTRL_A  = 4'h1;
  localparam logic [3:0] SEL_DATA_A  = 4'h3;
  localparam logic [3:0] SEL_CT_HI   = 4'h4;
  localparam logic [3:0] SEL_IRQ     = 4'h5;
  localparam logic [3:0] SEL_CT_LO   = 4'h6;
  localparam logic [3:0] SEL_CT_CTRL = 4'h7;
  localparam logic [3:0] SEL_CTRL_B  = 4'h9;
  localparam logic [3:0] SEL_DATA_B  = 4'hB;
  localparam logic [3:0] SEL_IVR     = 4'hC;
  localparam logic [3:0] SEL_OUTPUT_PORT_CONFIG_REG    = 4'hD;
  localparam logic [3:0] SEL_OP_SET  = 4'hE;
  localparam logic [3:0] SEL_OP_CLR  = 4'hF;
  // channel control fields
  localparam int unsigned CTL_RX_EN   = 0;
  localparam int unsigned CTL_TX_EN   = 1;
  localparam int unsigned CTL_LOOP    = 2;
  localparam int unsigned CTL_RTS_RX  = 3;
  localparam int unsigned CTL_RTS_TX  = 4;
  localparam int unsigned CTL_OVR_CLR = 5;
  // interrupt status bits
  localparam int unsigned ISR_TX_A = 0;
  localparam int unsigned ISR_RX_A = 1;
  localparam int unsigned ISR_CT   = 3;
  localparam int unsigned ISR_TX_B = 4;
  localparam int unsigned ISR_RX_B = 5;
  // reset values
  localparam logic [7:0]  IVR_RESET  = 8'h0F;
  localparam logic [7:0]  REG8_RESET = 8'h00;
  localparam logic [15:0] CT_RESET   = 16'h0000;
  // host-side AXI offsets, response codes and command bits
  localparam logic [3:0] AXI_CMD    = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  localparam int unsigned CMD_READ  = 12;
  localparam int unsigned CMD_IACK  = 13;
endpackage : duart_pkg

// File: duart_serial.sv
`timescale 1ns/10ps
module duart_serial (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick16,
  input  wire logic       rx_en,
  input  wire logic       tx_en,
  input  wire logic       loop_en,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_data,
  input  wire logic       rx_pop,
  input  wire logic       ovr_clear,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            tx_ready,
  output logic            tx_done,
  output logic            rx_ready,
  output logic            rx_overrun,
  output logic [7:0]      rx_data,
  output logic            tx_clk1x,
  output logic            rx_clk1x
);
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic [3:0] tx_ph_reg;
  logic       tx_busy_reg;
  logic [7:0] rx_shift_reg;
  logic [3:0] rx_bits_reg;
  logic [3:0] rx_ph_reg;
  logic       rx_busy_reg;
  logic       line;

  assign tx_ready = ~tx_busy_reg;
  assign tx_clk1x = tx_ph_reg[3];
  assign rx_clk1x = rx_ph_reg[3];
  assign line = loop_en ? (tx_busy_reg ? tx_shift_reg[0] : 1'b1) : serial_in;

  // transmitter: start, eight data bits lsb first, stop
  always_ff @(posedge aclk)
  begin
    tx_done <= 1'b0;
    if (!aresetn)
    begin
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg  <= 4'h0;
      tx_ph_reg    <= 4'h0;
      tx_busy_reg  <= 1'b0;
    end
    else if (tx_load && !tx_busy_reg)
    begin
      tx_shift_reg <= {1'b1, tx_data, 1'b0};
      tx_bits_reg  <= 4'h0;
      tx_ph_reg    <= 4'h0;
      tx_busy_reg  <= 1'b1;
    end
    else if (tick16 && tx_busy_reg)
    begin
      tx_ph_reg <= tx_ph_reg + 4'h1;
      if (tx_ph_reg == 4'hF)
      begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bits_reg  <= tx_bits_reg + 4'h1;
        if (tx_bits_reg == 4'h9)
        begin
          tx_busy_reg <= 1'b0;
          tx_done     <= 1'b1;
        end
      end
    end
  end

  // mark while disabled, idle or looped back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_out <= 1'b1;
    else
      serial_out <= (tx_busy_reg && tx_en && !loop_en) ?
                    tx_shift_reg[0] : 1'b1;
  end

  // receiver: mid-bit sampling, lsb first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_shift_reg <= 8'h00;
      rx_bits_reg  <= 4'h0;
      rx_ph_reg    <= 4'h0;
      rx_busy_reg  <= 1'b0;
    end
    else if (tick16)
    begin
      if (!rx_busy_reg)
      begin
        rx_busy_reg <= rx_en && !line;
        rx_ph_reg   <= 4'h0;
        rx_bits_reg <= 4'h0;
      end
      else
      begin
        rx_ph_reg <= rx_ph_reg + 4'h1;
        if (rx_ph_reg == 4'h7)
        begin
          rx_bits_reg <= rx_bits_reg + 4'h1;
          if (rx_bits_reg == 4'h0)
            rx_busy_reg <= !line;
          else if (rx_bits_reg <= 4'h8)
            rx_shift_reg <= {line, rx_shift_reg[7:1]};
          else
            rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  wire rx_deliver = tick16 && rx_busy_reg && rx_ph_reg == 4'h7 &&
                    rx_bits_reg == 4'h9;

  // holding register, ready and overrun flags; set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data    <= 8'h00;
      rx_ready   <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else
    begin
      if (rx_deliver)
        rx_data <= rx_shift_reg;
      rx_ready   <= rx_deliver || (rx_ready && !rx_pop);
      rx_overrun <= (rx_deliver && rx_ready && !rx_pop) ||
                    (rx_overrun && !ovr_clear);
    end
  end
endmodule : duart_serial
